// file: include/evc_pkg.sv
// Constants and register map of the event counter bank
package evc_pkg;

    // ============================================================
    // Geometry
    localparam int unsigned COUNTERS   = 256;
    localparam int unsigned IDX_W      = 8;
    localparam int unsigned VAL_W      = 16;
    localparam int unsigned DIGITS     = 4;
    localparam int unsigned NIB_W      = 4;
    localparam int unsigned ADDR_W     = 12;
    localparam int unsigned DATA_W     = 32;

    // ============================================================
    // Register byte offsets
    localparam logic [11:0] ADDR_SET_VALUE = 12'h000;
    localparam logic [11:0] ADDR_EXECUTE   = 12'h004;
    localparam logic [11:0] ADDR_BULK      = 12'h008;
    localparam logic [11:0] ADDR_STATUS    = 12'h00C;
    localparam logic [11:0] ADDR_READ_IDX  = 12'h010;
    localparam logic [11:0] ADDR_READ_DATA = 12'h014;

    // ============================================================
    // Execute register fields
    localparam int unsigned EX_IDX_LSB     = 0;
    localparam int unsigned EX_COUNT_BIT   = 8;
    localparam int unsigned EX_DEC_BIT     = 9;
    localparam int unsigned EX_RESET_BIT   = 10;
    localparam int unsigned EX_UPDOWN_BIT  = 11;
    localparam int unsigned EX_BCD_BIT     = 12;
    localparam int unsigned EX_FSET_BIT    = 13;
    localparam int unsigned EX_FRESET_BIT  = 14;

    // Bulk reset register fields
    localparam int unsigned BK_LO_LSB      = 0;
    localparam int unsigned BK_HI_LSB      = 8;
    localparam int unsigned BK_BCD_BIT     = 16;

    // Status and read data fields
    localparam int unsigned ST_ERROR_BIT   = 0;
    localparam int unsigned ST_BUSY_BIT    = 1;
    localparam int unsigned ST_FLAG_BIT    = 2;
    localparam int unsigned ST_PV_LSB      = 16;
    localparam int unsigned RD_FLAG_BIT    = 16;

    // ============================================================
    // Values
    localparam logic [15:0] VAL_ZERO       = 16'h0000;
    localparam logic [15:0] MAX_BCD        = 16'h9999;
    localparam logic [15:0] MAX_BIN        = 16'hFFFF;
    localparam logic [3:0]  DIGIT_MAX_BCD  = 4'h9;
    localparam logic [3:0]  DIGIT_MAX_BIN  = 4'hF;
    localparam logic [3:0]  DIGIT_ZERO     = 4'h0;
    localparam logic [3:0]  DIGIT_ONE      = 4'h1;
    localparam logic [1:0]  HIST_NONE      = 2'b00;
    localparam logic [31:0] WORD_ZERO      = 32'h0000_0000;

    // Boot wait before the strap is judged
    localparam logic [2:0]  BOOT_CYCLES    = 3'h4;

    typedef enum logic [1:0] {
        EVC_BOOT,
        EVC_IDLE,
        EVC_CLEAR,
        EVC_BULK
    } evc_state_t;

endpackage : evc_pkg

// file: logic/evc_core.sv
// Event counter bank with APB slave
//
// Overview of operation
// - 256 counter entries, each a present value word and completion flag.
// - Set value is four BCD digits or a 16-bit unsigned binary value.
// - Error flag raised for invalid BCD set value in BCD mode, else cleared.
// - Down counter decrements by one on each count input rising edge.
// - Present value changes only on edges; flag equals present value zero.
// - After reaching zero, down counter stays stopped until reset.
// - Down counter reset ON holds value at set value, flag clear.
// - Reset wins over a simultaneous count edge.
// - Forced set loads zero and flag; forced reset loads set value (zero in up/down), clears flag.
// - Values and flags survive loss of power and bus reset.
// - Clear strap wipes all values and flags at a power-up where it is held high.
// - All counter kinds share one storage array by index.
// - A new instance resumes from the value already stored.
// - Up/down counter steps on increment and decrement rising edges.
// - Increment from set value wraps to zero and sets flag.
// - Decrement from zero wraps to set value and sets flag.
// - Both edges together leave the present value unchanged.
// - Up/down reset ON holds value at zero, ignores counts.
// - Up/down flag set by a wrap or forced set, cleared by a step or reset, else held.
// - Bulk reset over an index range loads maximum and clears flags.
//
// The placing of the registers and the APB register port were decided locally.
`timescale 1ns/1ps
`default_nettype none

module evc_core
    import evc_pkg::*;
#(
    parameter int unsigned NUM_COUNTERS = evc_pkg::COUNTERS
) (
    // Clock and reset
    input  wire logic                      pclk,
    input  wire logic                      presetn,
    // APB slave
    input  wire logic                      psel,
    input  wire logic                      penable,
    input  wire logic                      pwrite,
    input  wire logic [evc_pkg::ADDR_W-1:0] paddr,
    input  wire logic [evc_pkg::DATA_W-1:0] pwdata,
    output logic      [evc_pkg::DATA_W-1:0] prdata,
    output logic                           pready,
    output logic                           pslverr,
    // Power-up clear strap
    input  wire logic                      clear_retained_pin,
    // Status
    output logic                           error_flag,
    output logic                           busy
);

    // ============================================================
    // Helpers

    // One step with digit carry; binary walks in radix 16
    function automatic logic [15:0] evc_step(input logic [15:0] v,
                                             input logic bcd,
                                             input logic up);
        logic [15:0] r;
        logic        carry;
        logic [3:0]  d;
        logic [3:0]  dmax;
        r     = v;
        carry = 1'b1;
        dmax  = bcd ? DIGIT_MAX_BCD : DIGIT_MAX_BIN;
        for (int i = 0; i < DIGITS; i++) begin
            d = v[i*NIB_W +: NIB_W];
            if (carry) begin
                if (up) begin
                    if (d >= dmax) begin
                        d = DIGIT_ZERO;
                    end else begin
                        d     = d + DIGIT_ONE;
                        carry = 1'b0;
                    end
                end else begin
                    if (d == DIGIT_ZERO) begin
                        d = dmax;
                    end else begin
                        d     = d - DIGIT_ONE;
                        carry = 1'b0;
                    end
                end
            end
            r[i*NIB_W +: NIB_W] = d;
        end
        return r;
    endfunction

    function automatic logic evc_bcd_ok(input logic [15:0] v);
        for (int i = 0; i < DIGITS; i++) begin
            if (v[i*NIB_W +: NIB_W] > DIGIT_MAX_BCD) begin
                return 1'b0;
            end
        end
        return 1'b1;
    endfunction

    // ============================================================
    // Storage

    // No reset on these arrays: they stand for retained memory
    logic [VAL_W-1:0] pv_mem   [0:NUM_COUNTERS-1];
    logic             flag_mem [0:NUM_COUNTERS-1];
    logic [1:0]       hist_mem [0:NUM_COUNTERS-1];

    // ============================================================
    // Registers and state

    evc_state_t        state_q;
    logic [2:0]        boot_cnt_q;
    logic [IDX_W-1:0]  sweep_q;
    logic [IDX_W-1:0]  bulk_hi_q;
    logic              bulk_bcd_q;
    logic              bulk_one_q;
    logic [VAL_W-1:0]  sv_q;
    logic [IDX_W-1:0]  rd_idx_q;
    logic              error_q;
    logic              last_flag_q;
    logic [VAL_W-1:0]  last_pv_q;
    logic [DATA_W-1:0] prdata_q;
    logic [2:0]        strap_sync_q;

    // ============================================================
    // APB decode

    logic apb_setup;
    logic apb_access;
    logic apb_write;
    logic sel_cmd;
    logic mapped;
    logic exec_fire;
    logic bulk_fire;

    assign busy       = (state_q != EVC_IDLE);
    assign apb_setup  = psel & ~penable;
    assign apb_access = psel & penable;

    always_comb begin
        sel_cmd = 1'b0;
        mapped  = 1'b1;
        if (paddr == ADDR_EXECUTE || paddr == ADDR_BULK) begin
            sel_cmd = 1'b1;
        end else if (paddr != ADDR_SET_VALUE && paddr != ADDR_STATUS
                     && paddr != ADDR_READ_IDX && paddr != ADDR_READ_DATA) begin
            mapped = 1'b0;
        end
    end

    // Commands wait while a sweep owns the array, so none is lost
    assign pready    = ~(busy & sel_cmd & pwrite & psel);
    assign pslverr   = apb_access & ~mapped;
    assign apb_write = apb_access & pwrite & pready & mapped;
    assign exec_fire = apb_write & (paddr == ADDR_EXECUTE);
    assign bulk_fire = apb_write & (paddr == ADDR_BULK);
    assign prdata    = prdata_q;
    assign error_flag = error_q;

    // ============================================================
    // Counter execution

    logic [IDX_W-1:0] ex_idx;
    logic             ex_cnt;
    logic             ex_dec;
    logic             ex_rst;
    logic             ex_updown;
    logic             ex_bcd;
    logic             ex_fset;
    logic             ex_freset;
    logic [VAL_W-1:0] old_pv;
    logic             old_flag;
    logic [1:0]       old_hist;
    logic             edge_a;
    logic             edge_b;
    logic             sv_bad;
    logic [VAL_W-1:0] new_pv;
    logic             new_flag;

    assign ex_idx    = pwdata[EX_IDX_LSB +: IDX_W];
    assign ex_cnt    = pwdata[EX_COUNT_BIT];
    assign ex_dec    = pwdata[EX_DEC_BIT];
    assign ex_rst    = pwdata[EX_RESET_BIT];
    assign ex_updown = pwdata[EX_UPDOWN_BIT];
    assign ex_bcd    = pwdata[EX_BCD_BIT];
    assign ex_fset   = pwdata[EX_FSET_BIT];
    assign ex_freset = pwdata[EX_FRESET_BIT];

    // Whatever is stored at the index is the starting point
    assign old_pv   = pv_mem[ex_idx];
    assign old_flag = flag_mem[ex_idx];
    assign old_hist = hist_mem[ex_idx];

    assign edge_a = ex_cnt & ~old_hist[0];
    assign edge_b = ex_dec & ~old_hist[1];
    assign sv_bad = ex_bcd & ~evc_bcd_ok(sv_q);

    always_comb begin
        new_pv   = old_pv;
        new_flag = old_flag;
        if (!ex_updown) begin
            if (ex_fset) begin
                new_pv   = VAL_ZERO;
                new_flag = 1'b1;
            end else if (ex_freset) begin
                new_pv   = sv_q;
                new_flag = 1'b0;
            end else if (ex_rst) begin
                // Reset first, so a count in the same execution is dropped
                new_pv   = sv_q;
                new_flag = 1'b0;
            end else begin
                if (edge_a && !old_flag && old_pv != VAL_ZERO) begin
                    new_pv = evc_step(old_pv, ex_bcd, 1'b0);
                end
                new_flag = (new_pv == VAL_ZERO);
            end
        end else begin
            if (ex_fset) begin
                new_pv   = VAL_ZERO;
                new_flag = 1'b1;
            end else if (ex_freset || ex_rst) begin
                new_pv   = VAL_ZERO;
                new_flag = 1'b0;
            end else if (edge_a && edge_b) begin
                new_pv   = old_pv;
            end else if (edge_a) begin
                // A value above the set value, e.g. after a bulk reset, wraps too
                if (old_pv >= sv_q) begin
                    new_pv   = VAL_ZERO;
                    new_flag = 1'b1;
                end else begin
                    new_pv   = evc_step(old_pv, ex_bcd, 1'b1);
                    new_flag = 1'b0;
                end
            end else if (edge_b) begin
                if (old_pv == VAL_ZERO) begin
                    new_pv   = sv_q;
                    new_flag = 1'b1;
                end else begin
                    new_pv   = evc_step(old_pv, ex_bcd, 1'b0);
                    new_flag = 1'b0;
                end
            end
        end
    end

    // ============================================================
    // Array write port

    always_ff @(posedge pclk) begin
        if (state_q == EVC_CLEAR) begin
            pv_mem[sweep_q]   <= VAL_ZERO;
            flag_mem[sweep_q] <= 1'b0;
            hist_mem[sweep_q] <= HIST_NONE;
        end else if (state_q == EVC_BULK) begin
            flag_mem[sweep_q] <= 1'b0;
            if (!bulk_one_q) begin
                pv_mem[sweep_q] <= bulk_bcd_q ? MAX_BCD : MAX_BIN;
            end
        end else if (exec_fire) begin
            // Input history follows every execution, reset included
            hist_mem[ex_idx] <= {ex_dec, ex_cnt};
            if (!sv_bad) begin
                pv_mem[ex_idx]   <= new_pv;
                flag_mem[ex_idx] <= new_flag;
            end
        end
    end

    // ============================================================
    // Power-up strap synchroniser

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            strap_sync_q <= 3'b000;
        end else begin
            strap_sync_q <= {strap_sync_q[1:0], clear_retained_pin};
        end
    end

    // ============================================================
    // Sweep sequencer

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q    <= EVC_BOOT;
            boot_cnt_q <= 3'b000;
            sweep_q    <= '0;
            bulk_hi_q  <= '0;
            bulk_bcd_q <= 1'b0;
            bulk_one_q <= 1'b0;
        end else begin
            case (state_q)
                EVC_BOOT: begin
                    boot_cnt_q <= boot_cnt_q + 3'b001;
                    // Strap judged once the synchroniser has settled
                    if (boot_cnt_q == BOOT_CYCLES) begin
                        sweep_q <= '0;
                        if (strap_sync_q[2] && strap_sync_q[1]) begin
                            state_q <= EVC_CLEAR;
                        end else begin
                            state_q <= EVC_IDLE;
                        end
                    end
                end
                EVC_IDLE: begin
                    if (bulk_fire) begin
                        sweep_q    <= pwdata[BK_LO_LSB +: IDX_W];
                        bulk_hi_q  <= pwdata[BK_HI_LSB +: IDX_W];
                        bulk_bcd_q <= pwdata[BK_BCD_BIT];
                        // Reversed range clears the first flag only
                        bulk_one_q <= pwdata[BK_LO_LSB +: IDX_W] > pwdata[BK_HI_LSB +: IDX_W];
                        state_q    <= EVC_BULK;
                    end
                end
                EVC_CLEAR: begin
                    sweep_q <= sweep_q + 1'b1;
                    if (sweep_q == IDX_W'(NUM_COUNTERS - 1)) begin
                        state_q <= EVC_IDLE;
                    end
                end
                EVC_BULK: begin
                    sweep_q <= sweep_q + 1'b1;
                    if (bulk_one_q || sweep_q == bulk_hi_q) begin
                        state_q <= EVC_IDLE;
                    end
                end
                default: begin
                    state_q <= EVC_IDLE;
                end
            endcase
        end
    end

    // ============================================================
    // Software registers

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sv_q     <= VAL_ZERO;
            rd_idx_q <= '0;
        end else if (apb_write) begin
            if (paddr == ADDR_SET_VALUE) begin
                sv_q <= pwdata[VAL_W-1:0];
            end else if (paddr == ADDR_READ_IDX) begin
                rd_idx_q <= pwdata[IDX_W-1:0];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            error_q     <= 1'b0;
            last_flag_q <= 1'b0;
            last_pv_q   <= VAL_ZERO;
        end else if (exec_fire) begin
            error_q <= sv_bad;
            if (!sv_bad) begin
                last_flag_q <= new_flag;
                last_pv_q   <= new_pv;
            end
        end else if (bulk_fire) begin
            error_q <= 1'b0;
        end
    end

    // Read data captured in the setup cycle, so reads have no wait state
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= WORD_ZERO;
        end else if (apb_setup) begin
            // Writes and unmapped reads show zero
            prdata_q <= WORD_ZERO;
            if (!pwrite && paddr == ADDR_SET_VALUE) begin
                prdata_q[VAL_W-1:0] <= sv_q;
            end else if (!pwrite && paddr == ADDR_STATUS) begin
                prdata_q[ST_ERROR_BIT]          <= error_q;
                prdata_q[ST_BUSY_BIT]           <= busy;
                prdata_q[ST_FLAG_BIT]           <= last_flag_q;
                prdata_q[ST_PV_LSB +: VAL_W]    <= last_pv_q;
            end else if (!pwrite && paddr == ADDR_READ_IDX) begin
                prdata_q[IDX_W-1:0] <= rd_idx_q;
            end else if (!pwrite && paddr == ADDR_READ_DATA) begin
                prdata_q[VAL_W-1:0] <= pv_mem[rd_idx_q];
                prdata_q[RD_FLAG_BIT] <= flag_mem[rd_idx_q];
            end
        end
    end

endmodule : evc_core // evc_core

`default_nettype wire

// file: test/evc_core_asserts.sv
// Port-level concurrent checks for the event counter bank
`timescale 1ns/1ps
`default_nettype none

module evc_core_asserts
    import evc_pkg::*;
#(
    parameter int unsigned NUM_COUNTERS = evc_pkg::COUNTERS
) (
    // Clock and reset
    input wire logic                       pclk,
    input wire logic                       presetn,
    // APB
    input wire logic                       psel,
    input wire logic                       penable,
    input wire logic                       pwrite,
    input wire logic [evc_pkg::ADDR_W-1:0] paddr,
    input wire logic [evc_pkg::DATA_W-1:0] pwdata,
    input wire logic [evc_pkg::DATA_W-1:0] prdata,
    input wire logic                       pready,
    input wire logic                       pslverr,
    // Strap and status
    input wire logic                       clear_retained_pin,
    input wire logic                       error_flag,
    input wire logic                       busy
);
    // ==========
    // Helpers
    logic wr_exec;
    logic wr_bulk;
    assign wr_exec = psel && penable && pready && pwrite && paddr == ADDR_EXECUTE;
    assign wr_bulk = psel && penable && pready && pwrite && paddr == ADDR_BULK;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // ==========
    // Checks
    a_err_binary_clear: assert property (wr_exec && !pwdata[EX_BCD_BIT] |=> !error_flag)
        else $error("error set by binary run");
    a_err_hold_idle: assert property (!wr_exec && !wr_bulk |=> $stable(error_flag))
        else $error("error flag moved");
    a_status_err: assert property (psel && penable && !pwrite && paddr == ADDR_STATUS
        |-> prdata[ST_ERROR_BIT] == $past(error_flag) && prdata[ST_BUSY_BIT] == $past(busy))
        else $error("status word mismatch");
    a_bulk_busy: assert property (wr_bulk && pwdata[15:8] >= pwdata[7:0] |=> busy)
        else $error("bulk sweep not started");
    a_bulk_single: assert property (wr_bulk && pwdata[15:8] == pwdata[7:0] |=> busy ##1 !busy)
        else $error("single bulk sweep length wrong");
    a_cmd_stall: assert property (psel && pwrite && busy
        && (paddr == ADDR_EXECUTE || paddr == ADDR_BULK) |-> !pready)
        else $error("command accepted during a sweep");
    a_boot_busy: assert property ($rose(presetn) |-> busy [*4])
        else $error("boot too short");
    a_read_free: assert property (psel && !pwrite |-> pready)
        else $error("read was stalled");
    a_unmapped: assert property (psel && penable && paddr > ADDR_READ_DATA
        |-> pslverr && prdata == WORD_ZERO)
        else $error("unmapped access not refused");
endmodule // evc_core_asserts

`default_nettype wire

// file: test/evc_ctrl_model.sv
// Controlling-program model: APB master
`timescale 1ns/1ps
`default_nettype none

module evc_ctrl_model (
    // Clock
    input  wire logic        pclk,
    // APB master side
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic [11:0]      paddr,
    output logic [31:0]      pwdata,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr
);
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
    end

    // Call after a rising edge
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                        output logic [31:0] r, output logic e);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (!pready) @(posedge pclk);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
endmodule // evc_ctrl_model

`default_nettype wire

// file: test/event_counter_bank_test.sv
// Self-checking bench for the event counter bank
`timescale 1ns/1ps
`default_nettype none

module event_counter_bank_test;
    import evc_pkg::*;

    // ==========
    // Signals and model state
    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        clear_retained_pin;
    logic        error_flag;
    logic        busy;
    logic [31:0] rdat;
    logic        rerr;
    logic [31:0] r;
    logic [15:0] pv_m [256];
    logic        fl_m [256];
    logic [1:0]  hist_m [256];
    logic [15:0] sv_m;
    logic        err_m;
    int          failures;
    int          samples_checked;
    int          cycles;
    integer      seed;

    evc_core #(.NUM_COUNTERS(256)) evc_core_i (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .clear_retained_pin(clear_retained_pin), .error_flag(error_flag), .busy(busy));
    evc_ctrl_model evc_ctrl_model_i (
        .pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

    always #5 pclk = ~pclk;

    // Hang guard
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 20000) begin
            failures++;
            complete_run;
        end
    end

    // ==========
    // Expectation functions
    function automatic logic [15:0] step(logic [15:0] v, logic up, logic bcd);
        logic [3:0] m;
        m = bcd ? DIGIT_MAX_BCD : DIGIT_MAX_BIN;
        for (int i = 0; i < 4; i++) begin
            if (up && v[i*4+:4] == m) v[i*4+:4] = DIGIT_ZERO;
            else if (!up && v[i*4+:4] == DIGIT_ZERO) v[i*4+:4] = m;
            else begin
                v[i*4+:4] = up ? v[i*4+:4] + DIGIT_ONE : v[i*4+:4] - DIGIT_ONE;
                break;
            end
        end
        return v;
    endfunction

    function automatic logic bcd_ok(logic [15:0] v);
        for (int i = 0; i < 4; i++) if (v[i*4+:4] > DIGIT_MAX_BCD) return 1'b0;
        return 1'b1;
    endfunction

    // c: count, dec, reset, updown, bcd, forced set, forced reset
    function automatic void mexec(logic [7:0] i, logic [6:0] c);
        logic ic;
        logic dc;
        logic [15:0] p;
        logic f;
        ic = c[0] && !hist_m[i][0];
        dc = c[1] && !hist_m[i][1];
        hist_m[i] = c[1:0];
        err_m = c[4] && !bcd_ok(sv_m);
        if (err_m) return;
        p = pv_m[i];
        f = fl_m[i];
        if (c[5]) begin
            p = VAL_ZERO;
            f = 1'b1;
        end else if (c[6] || c[2]) begin
            p = c[3] ? VAL_ZERO : sv_m;
            f = 1'b0;
        end else if (!c[3]) begin
            if (ic && !f && p != VAL_ZERO) p = step(p, 1'b0, c[4]);
            f = p == VAL_ZERO;
        end else if (ic && !dc) begin
            f = p >= sv_m;
            p = f ? VAL_ZERO : step(p, 1'b1, c[4]);
        end else if (dc && !ic) begin
            f = p == VAL_ZERO;
            p = f ? sv_m : step(p, 1'b0, c[4]);
        end
        pv_m[i] = p;
        fl_m[i] = f;
    endfunction

    function automatic void mbulk(logic [7:0] lo, logic [7:0] hi, logic bcd);
        if (lo > hi) fl_m[lo] = 1'b0;
        else for (int i = lo; i <= hi; i++) begin
            pv_m[i] = bcd ? MAX_BCD : MAX_BIN;
            fl_m[i] = 1'b0;
        end
    endfunction

    // ==========
    // Bench tasks
    task automatic chk(string n, logic [31:0] e, logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            failures++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic xf(logic w, logic [11:0] a, logic [31:0] d);
        evc_ctrl_model_i.xfer(w, a, d, rdat, rerr);
    endtask

    task automatic chk_idx(logic [7:0] i);
        xf(1'b1, ADDR_READ_IDX, 32'(i));
        xf(1'b0, ADDR_READ_DATA, '0);
        chk("counter", {15'h0000, fl_m[i], pv_m[i]}, rdat);
    endtask

    // Mode follows the index: bit 0 selects BCD, bit 1 up/down
    task automatic run(logic [7:0] i, logic [4:0] k);
        xf(1'b1, ADDR_EXECUTE, {17'h0_0000, k[4:3], i[0], i[1], k[2:0], i});
        mexec(i, {k[4:3], i[0], i[1], k[2:0]});
        chk("error_flag", 32'(err_m), 32'(error_flag));
        chk_idx(i);
    endtask

    task automatic pulse(logic [7:0] i, logic [4:0] k);
        run(i, k);
        run(i, 5'h00);
    endtask

    task automatic set_sv(logic [15:0] v);
        xf(1'b1, ADDR_SET_VALUE, {16'h0000, v});
        sv_m = v;
    endtask

    task automatic power_up(logic clr);
        presetn <= 1'b0;
        clear_retained_pin <= clr;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        while (busy) @(posedge pclk);
        sv_m = VAL_ZERO;
    endtask

    task automatic complete_run;
        $display("failures=%0d samples_checked=%0d", failures, samples_checked);
        if (failures == 0 && samples_checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    // ==========
    // Main sequence
    initial begin
        pclk = 1'b0;
        presetn = 1'b0;
        clear_retained_pin = 1'b1;
        seed = 19;
        for (int i = 0; i < 256; i++) begin
            pv_m[i] = VAL_ZERO;
            fl_m[i] = 1'b0;
            hist_m[i] = HIST_NONE;
        end
        power_up(1'b1);
        chk_idx(8'd255);
        xf(1'b1, 12'h01C, 32'h0000_1234);
        xf(1'b0, 12'h018, '0);
        chk("unmapped", 32'h0000_0001, {rdat[30:0], rerr});
        xf(1'b0, ADDR_SET_VALUE, '0);
        chk("set_value", 32'h0000_0000, rdat);
        set_sv(16'h0003);
        pulse(8'd0, 5'h04);
        repeat (4) pulse(8'd0, 5'h01);
        run(8'd0, 5'h05);
        run(8'd0, 5'h04);
        run(8'd0, 5'h05);
        pulse(8'd0, 5'h00);
        pulse(8'd0, 5'h01);
        set_sv(16'h0010);
        pulse(8'd3, 5'h04);
        repeat (12) pulse(8'd3, 5'h01);
        repeat (3) pulse(8'd3, 5'h02);
        pulse(8'd3, 5'h03);
        run(8'd3, 5'h04);
        run(8'd3, 5'h05);
        pulse(8'd2, 5'h04);
        pulse(8'd2, 5'h02);
        pulse(8'd2, 5'h01);
        for (int i = 1; i < 3; i++) begin
            run(i[7:0], 5'h08);
            run(i[7:0], 5'h10);
        end
        set_sv(16'h00A1);
        run(8'd1, 5'h01);
        xf(1'b0, ADDR_STATUS, '0);
        chk("status_error", 32'h0000_0001, 32'(rdat[ST_ERROR_BIT]));
        run(8'd0, 5'h00);
        mbulk(8'd0, 8'd3, 1'b1);
        xf(1'b1, ADDR_BULK, 32'h0001_0300);
        run(8'd1, 5'h00);
        for (int i = 0; i < 4; i++) chk_idx(i[7:0]);
        mbulk(8'd2, 8'd1, 1'b0);
        xf(1'b1, ADDR_BULK, 32'h0000_0102);
        mbulk(8'd0, 8'd0, 1'b0);
        xf(1'b1, ADDR_BULK, 32'h0000_0000);
        while (busy) @(posedge pclk);
        chk_idx(8'd2);
        pulse(8'd0, 5'h01);
        repeat (150) begin
            r = $random(seed);
            if (r[14:12] == 3'h0) set_sv(16'(r[20:16] % 19));
            run(8'(r[23:22]), {&r[6:4], &r[9:7], &r[11:10], r[1:0]});
        end
        power_up(1'b0);
        for (int i = 0; i < 4; i++) chk_idx(i[7:0]);
        chk("error_after_reset", 32'h0000_0000, 32'(error_flag));
        complete_run;
    end
endmodule // event_counter_bank_test

bind evc_core evc_core_asserts #(.NUM_COUNTERS(NUM_COUNTERS)) evc_core_asserts_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .clear_retained_pin(clear_retained_pin), .error_flag(error_flag), .busy(busy));

`default_nettype wire
